// [verilog/naci_core.sv]
// oscillator phase accumulator, double-buffered step value and bus registers
// Behaviour
// - accumulator is 20 bits over low, high and upper bytes; upper holds 19:16.
// - 24 bits of space reserved, 20 used; unused upper bits read zero.
// - accumulator runs on the oscillator input clock, reads show running value.
// - no coherent multi-byte snapshot of the accumulator is provided.
// - step value is 20 bits: low 7:0, high 15:8, upper nibble 19:16.
// - upper step register implements only its low four bits.
// - low step write commits all 20 bits to shadow at next input falling edge.
// - unimplemented bits read zero and ignore writes.
// - same reset values for every reset; step bit 0 resets to one.
// - accumulator overflow sets the overflow flag until software clears it.
// - without pulse mode the output toggles on each overflow.
// - pulse mode output active for 2 to the width field input periods.
`timescale 1ns/1ps

module naci_core #(
    parameter int ADDR_W = 32
) (
    // clock, reset and freeze
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              clockEnable,
    // bus slave
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // oscillator link
    input  wire logic              oscInputClock,
    output logic [3:0]             oscClockSelect,
    output logic                   oscOut,
    output logic                   irq
);

    // reset release through two flip-flops
    logic rstMeta;
    logic rstSync;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end
    // register state
    logic                           oscEnable;
    naci_pkg::naci_out_cfg_t        outCfg;
    logic [naci_pkg::CLK_SRC_W-1:0] clockSource;
    logic [naci_pkg::ACC_W-1:0]     phaseAccum;
    logic [naci_pkg::ACC_W-1:0]     stepValue;
    logic [naci_pkg::ACC_W-1:0]     stepShadow;
    logic                           commitPending;
    logic                           overflowFlag;
    logic                           overflowMask;
    logic                           toggleLevel;
    logic                           pulseActive;
    logic [naci_pkg::PULSE_CNT_W-1:0] pulseCount;
    logic                           oscPrev;
    naci_pkg::naci_addr_phase_t     addrPhase;
    logic                           readWait;
    logic [7:0]                     readAddr;

    // pulse length in input periods for a width code
    function automatic logic [naci_pkg::PULSE_CNT_W-1:0] pulseLen(
        input logic [naci_pkg::CLK_PWS_W-1:0] code
    );
        pulseLen = naci_pkg::PULSE_CNT_W'(1) << code;
    endfunction : pulseLen
    // read value of one register, zero for unused bits and holes
    function automatic logic [7:0] readByte(input logic [7:0] addr);
        logic [7:0] value;
        value = 8'h00;
        unique case (addr)
            naci_pkg::OFS_CONTROL:
            begin
                value[naci_pkg::CTL_ENABLE_BIT] = oscEnable;
                value[naci_pkg::CTL_OUT_BIT]    = oscOut;
                value[naci_pkg::CTL_POL_BIT]    = outCfg.polarity;
                value[naci_pkg::CTL_PFM_BIT]    = outCfg.pfm;
            end
            naci_pkg::OFS_CLOCK_SEL:
            begin
                value[naci_pkg::CLK_PWS_LSB +: naci_pkg::CLK_PWS_W] = outCfg.pws;
                value[naci_pkg::CLK_SRC_LSB +: naci_pkg::CLK_SRC_W] = clockSource;
            end
            naci_pkg::OFS_ACCUM_LOW:   value = phaseAccum[7:0];
            naci_pkg::OFS_ACCUM_HIGH:  value = phaseAccum[15:8];
            naci_pkg::OFS_ACCUM_UPPER: value = {4'h0, phaseAccum[19:16]};
            naci_pkg::OFS_STEP_LOW:    value = stepValue[7:0];
            naci_pkg::OFS_STEP_HIGH:   value = stepValue[15:8];
            naci_pkg::OFS_STEP_UPPER:  value = {4'h0, stepValue[19:16]};
            naci_pkg::OFS_IRQ_STATUS:  value[naci_pkg::IRQ_OVF_BIT] = overflowFlag;
            naci_pkg::OFS_IRQ_MASK:    value[naci_pkg::IRQ_OVF_BIT] = overflowMask;
            default:                   value = 8'h00;
        endcase
        readByte = value;
    endfunction : readByte

    // bus decode: accept an address phase, write in the data phase
    logic       accept;
    logic       wrStrobe;
    logic [7:0] wrAddr;
    logic [7:0] wrByte;
    assign accept    = hsel && htrans[naci_pkg::HTRANS_ACTIVE_BIT] && hready;
    assign wrStrobe  = clockEnable && addrPhase.valid && addrPhase.write && hready;
    assign wrAddr    = addrPhase.addr;
    assign wrByte    = hwdata[7:0];
    assign hreadyout = !readWait;
    assign hresp     = 1'b0;

    // address phase capture
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            addrPhase <= '0;
        end
        else if (clockEnable && hready)
        begin
            addrPhase.addr  <= haddr[7:0];
            addrPhase.write <= hwrite;
            addrPhase.valid <= accept;
        end
    end

    // reads take one wait state so a write just before is seen
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            readWait <= 1'b0;
            readAddr <= 8'h00;
            hrdata   <= 32'h00000000;
        end
        else if (clockEnable)
        begin
            if (accept && !hwrite)
            begin
                readWait <= 1'b1;
                readAddr <= haddr[7:0];
            end
            else if (readWait)
            begin
                readWait <= 1'b0;
                hrdata   <= {24'h000000, readByte(readAddr)};
            end
        end
    end

    // input clock edge detect, the input is synchronous to clock
    logic oscRise;
    logic oscFall;
    logic stepEdge;
    logic [naci_pkg::ACC_W:0] accSum;
    logic overflowEvt;
    assign oscRise     = oscInputClock && !oscPrev;
    assign oscFall     = !oscInputClock && oscPrev;
    assign stepEdge    = clockEnable && oscEnable && oscRise;
    assign accSum      = {1'b0, phaseAccum} + {1'b0, stepShadow};
    assign overflowEvt = stepEdge && accSum[naci_pkg::ACC_W];
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            oscPrev <= 1'b0;
        else if (clockEnable)
            oscPrev <= oscInputClock;
    end

    // control and clock select registers
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            oscEnable   <= 1'b0;
            outCfg      <= '0;
            clockSource <= '0;
        end
        else if (wrStrobe && wrAddr == naci_pkg::OFS_CONTROL)
        begin
            oscEnable       <= wrByte[naci_pkg::CTL_ENABLE_BIT];
            outCfg.polarity <= wrByte[naci_pkg::CTL_POL_BIT];
            outCfg.pfm      <= wrByte[naci_pkg::CTL_PFM_BIT];
        end
        else if (wrStrobe && wrAddr == naci_pkg::OFS_CLOCK_SEL)
        begin
            outCfg.pws  <= wrByte[naci_pkg::CLK_PWS_LSB +: naci_pkg::CLK_PWS_W];
            clockSource <= wrByte[naci_pkg::CLK_SRC_LSB +: naci_pkg::CLK_SRC_W];
        end
    end
    assign oscClockSelect = clockSource;

    // phase accumulator, stepped on input rising edges, byte writable
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            phaseAccum <= naci_pkg::ACCUM_RESET;
        else if (wrStrobe && wrAddr == naci_pkg::OFS_ACCUM_LOW)
            phaseAccum[7:0] <= wrByte;
        else if (wrStrobe && wrAddr == naci_pkg::OFS_ACCUM_HIGH)
            phaseAccum[15:8] <= wrByte;
        else if (wrStrobe && wrAddr == naci_pkg::OFS_ACCUM_UPPER)
            phaseAccum[19:16] <= wrByte[naci_pkg::UPPER_W-1:0];
        else if (stepEdge)
            phaseAccum <= accSum[naci_pkg::ACC_W-1:0];
    end
    // bytes are read live with no latch across them

    // step value bytes, upper keeps its low nibble only
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
            stepValue <= naci_pkg::STEP_RESET;
        else if (wrStrobe && wrAddr == naci_pkg::OFS_STEP_LOW)
            stepValue[7:0] <= wrByte;
        else if (wrStrobe && wrAddr == naci_pkg::OFS_STEP_HIGH)
            stepValue[15:8] <= wrByte;
        else if (wrStrobe && wrAddr == naci_pkg::OFS_STEP_UPPER)
            stepValue[19:16] <= wrByte[naci_pkg::UPPER_W-1:0];
    end

    // shadow commit on the input falling edge after a low byte write
    logic lowWrite;
    assign lowWrite = wrStrobe && wrAddr == naci_pkg::OFS_STEP_LOW;
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            commitPending <= 1'b0;
            stepShadow    <= naci_pkg::STEP_RESET;
        end
        else if (clockEnable)
        begin
            if (commitPending && oscFall)
                stepShadow <= stepValue;
            if (lowWrite)
                commitPending <= 1'b1; // a new write wins over clearing the pending commit
            else if (oscFall)
                commitPending <= 1'b0;
        end
    end

    // overflow flag and mask, write one to clear, set wins
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            overflowFlag <= 1'b0;
            overflowMask <= 1'b0;
        end
        else if (clockEnable)
        begin
            if (overflowEvt)
                overflowFlag <= 1'b1;
            else if (wrStrobe && wrAddr == naci_pkg::OFS_IRQ_STATUS
                     && wrByte[naci_pkg::IRQ_OVF_BIT])
                overflowFlag <= 1'b0;
            if (wrStrobe && wrAddr == naci_pkg::OFS_IRQ_MASK)
                overflowMask <= wrByte[naci_pkg::IRQ_OVF_BIT];
        end
    end

    // output stage: toggle or stretched pulse
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            toggleLevel <= 1'b0;
            pulseActive <= 1'b0;
            pulseCount  <= '0;
        end
        else if (clockEnable)
        begin
            if (!oscEnable)
            begin
                pulseActive <= 1'b0;
                pulseCount  <= '0;
            end
            else if (overflowEvt && !outCfg.pfm)
                toggleLevel <= !toggleLevel;
            else if (overflowEvt)
            begin
                pulseActive <= 1'b1;
                pulseCount  <= pulseLen(outCfg.pws);
            end
            else if (stepEdge && pulseActive)
            begin
                pulseCount  <= pulseCount - 1'b1;
                pulseActive <= (pulseCount != 8'h01);
            end
        end
    end

    // registered output with polarity, and interrupt level
    always_ff @(posedge clock or negedge rstSync)
    begin
        if (!rstSync)
        begin
            oscOut <= 1'b0;
            irq    <= 1'b0;
        end
        else if (clockEnable)
        begin
            oscOut <= (outCfg.pfm ? pulseActive : toggleLevel) ^ outCfg.polarity;
            irq    <= overflowFlag && overflowMask;
        end
    end

    // checks of accumulator, shadow, flag and bus timing
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstSync);
    accum_step_a: assert property (stepEdge && !wrStrobe
        |=> phaseAccum == $past(accSum[naci_pkg::ACC_W-1:0]))
        else $error("accumulator did not step by shadow");
    accum_hold_a: assert property (clockEnable && !oscEnable && !wrStrobe
        |=> $stable(phaseAccum))
        else $error("accumulator moved while disabled");
    shadow_commit_a: assert property (clockEnable && commitPending && oscFall
        |=> stepShadow == $past(stepValue))
        else $error("shadow missed commit on falling edge");
    shadow_hold_a: assert property (!(commitPending && oscFall && clockEnable)
        |=> $stable(stepShadow))
        else $error("shadow changed without commit");
    flag_set_a: assert property (overflowEvt
        ##1 !(wrStrobe && wrAddr == naci_pkg::OFS_IRQ_STATUS)
        |-> overflowFlag [*2])
        else $error("overflow flag not held");
    toggle_out_a: assert property (overflowEvt && oscEnable && !outCfg.pfm
        |=> toggleLevel != $past(toggleLevel))
        else $error("output did not toggle on overflow");
    pulse_load_a: assert property (overflowEvt && oscEnable && outCfg.pfm
        |=> pulseActive && pulseCount == pulseLen($past(outCfg.pws)))
        else $error("pulse length wrong");
    read_zero_a: assert property ($fell(readWait)
        |-> hrdata[31:8] == 24'h000000)
        else $error("unused read bits not zero");
    upper_zero_a: assert property ($fell(readWait)
        && ($past(readAddr) == naci_pkg::OFS_ACCUM_UPPER
        || $past(readAddr) == naci_pkg::OFS_STEP_UPPER)
        |-> hrdata[7:4] == 4'h0)
        else $error("upper nibble not zero");
    step_reset_a: assert property ($rose(rstSync)
        |-> stepValue == naci_pkg::STEP_RESET)
        else $error("step reset value wrong");
    read_wait_a: assert property (clockEnable && accept && !hwrite
        |=> !hreadyout)
        else $error("read wait state missing");
    pfm_overflow_c: cover property (overflowEvt && outCfg.pfm);
    commit_seen_c:  cover property (commitPending && oscFall && clockEnable);
    flag_clear_c:   cover property (overflowFlag ##1 !overflowFlag);
    read_upper_c:   cover property (readWait && readAddr == naci_pkg::OFS_ACCUM_UPPER);

endmodule : naci_core

// [common/naci_pkg.sv]
// shared constants and types for the oscillator accumulator and step registers
package naci_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_CONTROL     = 8'h00;
    localparam logic [7:0] OFS_CLOCK_SEL   = 8'h04;
    localparam logic [7:0] OFS_ACCUM_LOW   = 8'h08;
    localparam logic [7:0] OFS_ACCUM_HIGH  = 8'h0C;
    localparam logic [7:0] OFS_ACCUM_UPPER = 8'h10;
    localparam logic [7:0] OFS_STEP_LOW    = 8'h14;
    localparam logic [7:0] OFS_STEP_HIGH   = 8'h18;
    localparam logic [7:0] OFS_STEP_UPPER  = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h24;

    // accumulator and step widths
    localparam int ACC_W   = 20;
    localparam int UPPER_W = 4;

    // control register fields
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_OUT_BIT    = 5;
    localparam int CTL_POL_BIT    = 4;
    localparam int CTL_PFM_BIT    = 0;

    // clock select register fields
    localparam int CLK_PWS_LSB = 5;
    localparam int CLK_PWS_W   = 3;
    localparam int CLK_SRC_LSB = 0;
    localparam int CLK_SRC_W   = 4;

    // interrupt status and mask fields
    localparam int IRQ_OVF_BIT = 0;

    // reset values
    localparam logic [ACC_W-1:0] STEP_RESET  = 20'h00001;
    localparam logic [ACC_W-1:0] ACCUM_RESET = 20'h00000;
    localparam logic [7:0]       BYTE_RESET  = 8'h00;

    // pulse counter width, enough for 128 periods
    localparam int PULSE_CNT_W = 8;

    // bus transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;

    // one captured address phase
    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       valid;
    } naci_addr_phase_t;

    // output stage configuration
    typedef struct packed {
        logic                 pfm;
        logic                 polarity;
        logic [CLK_PWS_W-1:0] pws;
    } naci_out_cfg_t;

endpackage : naci_pkg

// [sim/test_nco_accumulator_increment_regs.sv]
// self-checking bench for the oscillator accumulator and step registers
`timescale 1ns/1ps

module test_nco_accumulator_increment_regs;

    logic        clock;
    logic        rst_n;
    logic        clockEnable;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyOut;
    logic        hresp;
    logic [31:0] hrdata;
    logic        oscInputClock;
    logic [3:0]  oscClockSelect;
    logic        oscOut;
    logic        irq;
    logic [31:0] readData;
    int          errTotal;
    int          compares;
    int          cycleCount;

    naci_core DUT (
        .clock         (clock),
        .rst_n         (rst_n),
        .clockEnable   (clockEnable),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hreadyOut),
        .hreadyout     (hreadyOut),
        .hresp         (hresp),
        .hrdata        (hrdata),
        .oscInputClock (oscInputClock),
        .oscClockSelect(oscClockSelect),
        .oscOut        (oscOut),
        .irq           (irq)
    );

    // 50 MHz system clock
    always #10 clock = ~clock;

    // hang guard: a stuck wait ends the run as a failure
    always @(posedge clock)
    begin
        cycleCount++;
        if (cycleCount == 20000)
        begin
            errTotal++;
            testDone();
        end
    end

    // compare one value and count it
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want)
        begin
            errTotal++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // single AHB-Lite transfer, each phase held until hready is high at a rising edge
    task automatic busXfer(input logic [7:0] ofs, input logic wr, input logic [7:0] data);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, ofs};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clock);
        while (hreadyOut !== 1'b1) @(posedge clock);
        htrans <= 2'b00;
        hwdata <= {24'h000000, data};
        @(posedge clock);
        while (hreadyOut !== 1'b1) @(posedge clock);
        readData = hrdata;
    endtask : busXfer

    task automatic busWrite(input logic [7:0] ofs, input logic [7:0] data);
        busXfer(ofs, 1'b1, data);
    endtask : busWrite

    task automatic readCheck(input logic [7:0] ofs, input logic [7:0] want);
        busXfer(ofs, 1'b0, 8'h00);
        check(readData, {24'h000000, want});
    endtask : readCheck

    // accumulator load, only while the oscillator is disabled
    task automatic setAccum(input logic [19:0] value);
        busWrite(naci_pkg::OFS_ACCUM_LOW, value[7:0]);
        busWrite(naci_pkg::OFS_ACCUM_HIGH, value[15:8]);
        busWrite(naci_pkg::OFS_ACCUM_UPPER, {4'h0, value[19:16]});
    endtask : setAccum

    // whole input clock periods, slow against the system clock
    task automatic oscPulse(input int n);
        repeat (n)
        begin
            @(posedge clock);
            oscInputClock <= 1'b1;
            repeat (8) @(posedge clock);
            oscInputClock <= 1'b0;
            repeat (8) @(posedge clock);
        end
        @(negedge clock);
    endtask : oscPulse

    // reset values of every register and an unmapped offset
    task automatic testReset();
        readCheck(naci_pkg::OFS_CONTROL, 8'h00);
        readCheck(naci_pkg::OFS_CLOCK_SEL, 8'h00);
        readCheck(naci_pkg::OFS_ACCUM_LOW, 8'h00);
        readCheck(naci_pkg::OFS_ACCUM_HIGH, 8'h00);
        readCheck(naci_pkg::OFS_ACCUM_UPPER, 8'h00);
        readCheck(naci_pkg::OFS_STEP_LOW, 8'h01);
        readCheck(naci_pkg::OFS_STEP_HIGH, 8'h00);
        readCheck(naci_pkg::OFS_STEP_UPPER, 8'h00);
        readCheck(naci_pkg::OFS_IRQ_STATUS, 8'h00);
        readCheck(naci_pkg::OFS_IRQ_MASK, 8'h00);
        readCheck(8'h30, 8'h00);
        check({31'h0, hresp}, 32'h0);
        $display("test reset finished");
    endtask : testReset

    // byte placement and unimplemented bits
    task automatic testFields();
        setAccum(20'hFF5A5);
        busWrite(naci_pkg::OFS_ACCUM_UPPER, 8'hFF);
        readCheck(naci_pkg::OFS_ACCUM_LOW, 8'hA5);
        readCheck(naci_pkg::OFS_ACCUM_HIGH, 8'hF5);
        readCheck(naci_pkg::OFS_ACCUM_UPPER, 8'h0F);
        busWrite(naci_pkg::OFS_STEP_UPPER, 8'hF3);
        readCheck(naci_pkg::OFS_STEP_UPPER, 8'h03);
        busWrite(naci_pkg::OFS_CONTROL, 8'h4E);
        readCheck(naci_pkg::OFS_CONTROL, 8'h00);
        busWrite(naci_pkg::OFS_CLOCK_SEL, 8'hFF);
        readCheck(naci_pkg::OFS_CLOCK_SEL, 8'hEF);
        check({28'h0, oscClockSelect}, 32'hF);
        busWrite(naci_pkg::OFS_CLOCK_SEL, 8'h00);
        setAccum(20'h00000);
        $display("test fields finished");
    endtask : testFields

    // step commits whole on the falling edge after the low write
    task automatic testShadow();
        busWrite(naci_pkg::OFS_STEP_UPPER, 8'h01);
        busWrite(naci_pkg::OFS_STEP_HIGH, 8'h00);
        busWrite(naci_pkg::OFS_STEP_LOW, 8'h10);
        readCheck(naci_pkg::OFS_STEP_LOW, 8'h10);
        busWrite(naci_pkg::OFS_CONTROL, 8'h80);
        oscPulse(1);
        readCheck(naci_pkg::OFS_ACCUM_LOW, 8'h01);
        oscPulse(1);
        readCheck(naci_pkg::OFS_ACCUM_LOW, 8'h11);
        readCheck(naci_pkg::OFS_ACCUM_UPPER, 8'h01);
        // clock enable low freezes the accumulator through a whole input period
        clockEnable <= 1'b0;
        oscPulse(1);
        @(posedge clock);
        clockEnable <= 1'b1;
        readCheck(naci_pkg::OFS_ACCUM_LOW, 8'h11);
        busWrite(naci_pkg::OFS_CONTROL, 8'h00);
        $display("test shadow finished");
    endtask : testShadow

    // overflow flag, interrupt masking and divide-by-two output
    task automatic testOverflow();
        setAccum(20'hFFFF0);
        busWrite(naci_pkg::OFS_IRQ_MASK, 8'h01);
        busWrite(naci_pkg::OFS_CONTROL, 8'h80);
        oscPulse(1);
        readCheck(naci_pkg::OFS_ACCUM_UPPER, 8'h01);
        readCheck(naci_pkg::OFS_IRQ_STATUS, 8'h01);
        check({31'h0, irq}, 32'h1);
        check({31'h0, oscOut}, 32'h1);
        readCheck(naci_pkg::OFS_CONTROL, 8'hA0);
        oscPulse(1);
        readCheck(naci_pkg::OFS_IRQ_STATUS, 8'h01);
        busWrite(naci_pkg::OFS_IRQ_STATUS, 8'h01);
        readCheck(naci_pkg::OFS_IRQ_STATUS, 8'h00);
        check({31'h0, irq}, 32'h0);
        busWrite(naci_pkg::OFS_CONTROL, 8'h00);
        setAccum(20'hFFFF0);
        busWrite(naci_pkg::OFS_IRQ_MASK, 8'h00);
        busWrite(naci_pkg::OFS_CONTROL, 8'h80);
        oscPulse(1);
        readCheck(naci_pkg::OFS_IRQ_STATUS, 8'h01);
        check({31'h0, irq}, 32'h0);
        check({31'h0, oscOut}, 32'h0);
        busWrite(naci_pkg::OFS_IRQ_STATUS, 8'h01);
        busWrite(naci_pkg::OFS_CONTROL, 8'h00);
        $display("test overflow finished");
    endtask : testOverflow

    // pulse mode with width code 1 holds the output for two input periods
    task automatic testPulse();
        busWrite(naci_pkg::OFS_CLOCK_SEL, 8'h20);
        setAccum(20'hFFFF0);
        busWrite(naci_pkg::OFS_CONTROL, 8'h81);
        oscPulse(1);
        check({31'h0, oscOut}, 32'h1);
        oscPulse(1);
        check({31'h0, oscOut}, 32'h1);
        oscPulse(1);
        check({31'h0, oscOut}, 32'h0);
        // inverted polarity turns the idle pulse output high
        busWrite(naci_pkg::OFS_CONTROL, 8'h91);
        readCheck(naci_pkg::OFS_CONTROL, 8'hB1);
        check({31'h0, oscOut}, 32'h1);
        busWrite(naci_pkg::OFS_CONTROL, 8'h00);
        $display("test pulse finished");
    endtask : testPulse

    // verdict and end of run
    task automatic testDone();
        $display("comparisons %0d, mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : testDone

    // reset, then the scenarios in order
    initial
    begin
        clock         = 1'b0;
        rst_n         = 1'b0;
        clockEnable   = 1'b1;
        hsel          = 1'b0;
        haddr         = 32'h00000000;
        htrans        = 2'b00;
        hwrite        = 1'b0;
        hsize         = 3'h2;
        hwdata        = 32'h00000000;
        oscInputClock = 1'b0;
        errTotal      = 0;
        compares      = 0;
        cycleCount    = 0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        repeat (6) @(posedge clock);
        testReset();
        testFields();
        testShadow();
        testOverflow();
        testPulse();
        testDone();
    end

endmodule : test_nco_accumulator_increment_regs
